// *** rtl/ipdw_pkg.sv ***
package ipdw_pkg;

	// ==========================================================
	// register indices (byte address = index * 4)
	localparam logic [9:0] IDX_IRQ_FLAGS  = 10'h0C2;
	localparam logic [9:0] IDX_IRQ_CLEAR  = 10'h0C3;
	localparam logic [9:0] IDX_TAP_CLEAR  = 10'h0CC;
	localparam logic [9:0] IDX_TAP_FLAGS  = 10'h0CD;
	localparam logic [9:0] IDX_CLK_SELECT = 10'h0CE;
	localparam logic [9:0] IDX_DIV_UPPER  = 10'h0CF;
	localparam logic [9:0] IDX_WDOG_CTRL  = 10'h0DE;
	localparam logic [9:0] IDX_PWR_CTRL   = 10'h200;
	localparam logic [9:0] IDX_HALT_WAKE  = 10'h202;

	localparam int ADR_W = 12;
	localparam int DAT_W = 32;

	// ==========================================================
	// field positions
	localparam int BIT_KEY   = 1;
	localparam int BIT_PORT0 = 2;
	localparam int BIT_TMR1  = 3;
	localparam int BIT_TMR2  = 4;
	localparam int BIT_DIV   = 5;
	localparam int BIT_CPU_CHOICE = 0;
	localparam int BIT_DIV_CHOICE = 7;
	localparam int BIT_HALT   = 0;
	localparam int BIT_MAIN_C = 1;
	localparam int BIT_XTAL_C = 2;
	localparam int BIT_WD_CLR  = 0;
	localparam int BIT_WD_SEEN = 7;

	// divider taps: register bit and counter bit of each tap
	localparam int N_TAPS = 4;
	localparam int TAP_REG_BIT [N_TAPS] = '{0, 1, 4, 7};
	localparam int TAP_CNT_BIT [N_TAPS] = '{1, 9, 12, 15};
	localparam int DIV_W = 16;
	localparam int WD_W  = 6;
	// watchdog steps on the rise of this divider bit
	localparam int WD_STEP_BIT = 9;

	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [4:0]  EN_RESET  = 5'h00;
	localparam logic [1:0]  OSC_DUAL   = 2'h0;
	localparam logic [1:0]  OSC_SINGLE = 2'h1;
	localparam logic [1:0]  OSC_SLOW   = 2'h2;
	localparam logic [1:0]  OSC_STOP   = 2'h3;

	typedef enum logic [1:0] {
		IPDW_DUAL,
		IPDW_SINGLE,
		IPDW_SLOW,
		IPDW_STOP
	} ipdw_osc_mode_t;

	// same-clock event pulses from the neighbouring blocks
	typedef struct packed {
		logic key_strobe;
		logic first_timer_event;
		logic second_timer_event;
	} ipdw_events_t;

endpackage

// *** rtl/ipdw_top.sv ***
`timescale 1ns/1ps
// Behaviour
// (RQ1) edge either way on port-zero pin zero or pin four, when input, sets port flag
// (RQ2) timer one or two underflow sets its flag
// (RQ3) status flags stay set until software clears them
// (RQ4) writing one to clear register bit clears that flag; firmware clears after service
// (RQ5) divider status flag is the OR of the tap flags
// (RQ6) firmware clears divider flag and every tap flag before the next divider interrupt
// (RQ7) cpu clock choice: zero crystal, one main oscillator
// (RQ8) clock select bit seven picks divider input: zero crystal, one main
// (RQ9) 16-bit divider; upper byte readable, bit0 input/512 up to input/65536
// (RQ10) four taps /4 /1024 /8192 /65536 with enable and status at one address
// (RQ11) writing one to tap clear bit clears that tap flag alone
// (RQ12) divider and tap flags cleared by resets and by wake from stop
// (RQ13) oscillator field: 00 dual, 01 main only, 10 crystal only, 11 stop
// (RQ14) single-clock option ignores the low oscillator control bit
// (RQ15) halt bit gates cpu clock, oscillators keep running
// (RQ16) stop left only on enabled pending port interrupt or resets
// (RQ17) leaving stop restarts only the oscillator feeding the cpu
// (RQ18) halt released by events enabled in halt wake register, or resets
// (RQ19) optional 6-bit watchdog whose overflow restarts the processor
// (RQ20) watchdog overflow acts as hardware reset but sets reset-seen bit
// (RQ21) writing one to watchdog bit zero clears counter and reset-seen bit
// (RQ22) firmware restarts the watchdog before overflow
// (RQ23) interrupt requested when a flag and its enable are both one; enables reset zero
// (RQ24) each enabled tap sets its flag once per divided period on one edge
module ipdw_top (
	input  wire logic                        clk_sys,
	input  wire logic                        reset_n,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [ipdw_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [ipdw_pkg::DAT_W-1:0]  wb_dat_i,
	output logic      [ipdw_pkg::DAT_W-1:0]  wb_dat_o,
	output logic                             wb_ack_o,
	input  wire ipdw_pkg::ipdw_events_t      events_i,
	input  wire logic                        port_zero_pin_zero,
	input  wire logic                        port_zero_pin_four,
	input  wire logic                        pin_zero_is_output,
	input  wire logic                        pin_four_is_output,
	input  wire logic                        main_osc_clock,
	input  wire logic                        slow_crystal_clock,
	input  wire logic                        single_clock_option,
	input  wire logic                        watchdog_option,
	output logic                             irq_request,
	output logic                             processor_clock_enable,
	output logic                             main_osc_enable,
	output logic                             crystal_osc_enable,
	output logic                             cpu_clock_choice,
	output logic                             hot_reset
);

	// ==========================================================
	// bus decode
	logic        ack_q;
	logic [31:0] rdata_q;
	wire  [9:0]  reg_idx  = wb_adr_i[ipdw_pkg::ADR_W-1:2];
	wire         bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
	// writes land at the edge where the master samples ack high, not one edge early
	wire         wr_byte  = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
	wire  [7:0]  wr_data  = wb_dat_i[7:0];
	wire         wr_en_reg   = wr_byte & (reg_idx == ipdw_pkg::IDX_IRQ_FLAGS);
	wire         wr_interrupt_flag_clear  = wr_byte & (reg_idx == ipdw_pkg::IDX_IRQ_CLEAR);
	wire         wr_tap_clr  = wr_byte & (reg_idx == ipdw_pkg::IDX_TAP_CLEAR);
	wire         wr_tap_en   = wr_byte & (reg_idx == ipdw_pkg::IDX_TAP_FLAGS);
	wire         wr_clk_sel  = wr_byte & (reg_idx == ipdw_pkg::IDX_CLK_SELECT);
	wire         wr_wdog     = wr_byte & (reg_idx == ipdw_pkg::IDX_WDOG_CTRL);
	wire         wr_pwr      = wr_byte & (reg_idx == ipdw_pkg::IDX_PWR_CTRL);
	wire         wr_halt_wk  = wr_byte & (reg_idx == ipdw_pkg::IDX_HALT_WAKE);

	// ==========================================================
	// state
	logic [5:1]  irq_en_q;
	logic [4:1]  irq_flag_q, irq_flag_d;
	logic [7:0]  tap_en_q;
	logic [7:0]  tap_flag_q, tap_flag_d;
	logic        cpu_choice_q;
	logic        div_choice_q;
	logic [1:0]  osc_ctrl_q, osc_ctrl_d;
	logic        halt_q, halt_d;
	logic [5:1]  halt_wake_q;
	logic [15:0] div_q;
	logic [5:0]  wd_q;
	logic        wd_seen_q;
	logic        hot_q;
	logic        irq_q;
	logic        cpu_en_q;
	logic        main_en_q;
	logic        xtal_en_q;

	// hot reset clears like a hardware reset
	wire         clr_all = ~reset_n | hot_q; // RQ20

	// ==========================================================
	// pin synchronisers: three stages, a change counts when stages two and three agree
	logic [2:0]  p0_s, p4_s, mo_s, xt_s;
	logic        p0_f_q, p4_f_q, mo_f_q, xt_f_q;
	always_ff @(posedge clk_sys) begin
		p0_s <= {p0_s[1:0], port_zero_pin_zero};
		p4_s <= {p4_s[1:0], port_zero_pin_four};
		mo_s <= {mo_s[1:0], main_osc_clock};
		xt_s <= {xt_s[1:0], slow_crystal_clock};
	end
	wire p0_ok = p0_s[1] == p0_s[2];
	wire p4_ok = p4_s[1] == p4_s[2];
	wire mo_ok = mo_s[1] == mo_s[2];
	wire xt_ok = xt_s[1] == xt_s[2];
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			p0_f_q <= 1'b0;
			p4_f_q <= 1'b0;
			mo_f_q <= 1'b0;
			xt_f_q <= 1'b0;
		end else begin
			p0_f_q <= p0_ok ? p0_s[2] : p0_f_q;
			p4_f_q <= p4_ok ? p4_s[2] : p4_f_q;
			mo_f_q <= mo_ok ? mo_s[2] : mo_f_q;
			xt_f_q <= xt_ok ? xt_s[2] : xt_f_q;
		end
	end
	// output pins are masked so driving them raises no event
	wire p0_edge = p0_ok & (p0_s[2] != p0_f_q) & ~pin_zero_is_output; // RQ1
	wire p4_edge = p4_ok & (p4_s[2] != p4_f_q) & ~pin_four_is_output; // RQ1
	wire mo_tick = mo_ok & mo_s[2] & ~mo_f_q;
	wire xt_tick = xt_ok & xt_s[2] & ~xt_f_q;

	// ==========================================================
	// divider
	wire         div_src_tick = div_choice_q ? (mo_tick & main_en_q) : (xt_tick & xtal_en_q); // RQ8
	wire  [15:0] div_inc      = div_q + 16'h0001;
	wire         stop_mode    = osc_ctrl_q == ipdw_pkg::OSC_STOP;
	wire         stop_wake    = stop_mode & irq_en_q[ipdw_pkg::BIT_PORT0] & irq_flag_q[ipdw_pkg::BIT_PORT0]; // RQ16
	wire [7:0]   tap_rise;

	always_ff @(posedge clk_sys) begin
		if (clr_all || stop_wake) begin
			div_q <= 16'h0000; // RQ12
		end else if (div_src_tick) begin
			div_q <= div_inc; // RQ9
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_tap_bit
			localparam int K = (gi == 0) ? 0 : (gi == 1) ? 1 : (gi == 4) ? 2 : (gi == 7) ? 3 : -1;
			if (K >= 0) begin : g_tap
				localparam int CB = ipdw_pkg::TAP_CNT_BIT[K];
				// one rising edge of the tap per divided period
				assign tap_rise[gi] = div_src_tick & ~div_q[CB] & div_inc[CB]; // RQ24
			end else begin : g_none
				assign tap_rise[gi] = 1'b0;
			end
		end
	endgenerate

	// set wins over a simultaneous clear
	always_comb begin
		tap_flag_d = tap_flag_q;
		if (wr_tap_clr) begin
			tap_flag_d = tap_flag_d & ~wr_data; // RQ11
		end
		tap_flag_d = tap_flag_d | (tap_rise & tap_en_q); // RQ10
	end

	always_ff @(posedge clk_sys) begin
		if (clr_all || stop_wake) begin
			tap_flag_q <= ipdw_pkg::BYTE_ZERO; // RQ12
		end else begin
			tap_flag_q <= tap_flag_d;
		end
	end

	// ==========================================================
	// interrupt flags
	wire div_flag = |tap_flag_q; // RQ5
	wire [5:1] flags_all = {div_flag, irq_flag_q};

	always_comb begin
		irq_flag_d = irq_flag_q;
		if (wr_interrupt_flag_clear) begin
			irq_flag_d = irq_flag_d & ~wr_data[4:1]; // RQ4
		end
		irq_flag_d[ipdw_pkg::BIT_KEY]   = irq_flag_d[ipdw_pkg::BIT_KEY] | events_i.key_strobe;
		irq_flag_d[ipdw_pkg::BIT_PORT0] = irq_flag_d[ipdw_pkg::BIT_PORT0] | p0_edge | p4_edge; // RQ1
		irq_flag_d[ipdw_pkg::BIT_TMR1]  = irq_flag_d[ipdw_pkg::BIT_TMR1] | events_i.first_timer_event; // RQ2
		irq_flag_d[ipdw_pkg::BIT_TMR2]  = irq_flag_d[ipdw_pkg::BIT_TMR2] | events_i.second_timer_event; // RQ2
	end

	always_ff @(posedge clk_sys) begin
		if (clr_all) begin
			irq_flag_q <= 4'h0;
			irq_en_q   <= ipdw_pkg::EN_RESET; // RQ23
			tap_en_q   <= ipdw_pkg::BYTE_ZERO;
			halt_wake_q <= ipdw_pkg::EN_RESET;
		end else begin
			irq_flag_q <= irq_flag_d; // RQ3
			if (wr_en_reg) begin
				irq_en_q <= wr_data[5:1];
			end
			if (wr_tap_en) begin
				tap_en_q <= wr_data & 8'h93;
			end
			if (wr_halt_wk) begin
				halt_wake_q <= wr_data[5:1];
			end
		end
	end

	// ==========================================================
	// clock selection and power modes
	always_comb begin
		osc_ctrl_d = osc_ctrl_q;
		halt_d     = halt_q;
		if (wr_pwr) begin
			osc_ctrl_d = {wr_data[ipdw_pkg::BIT_XTAL_C], wr_data[ipdw_pkg::BIT_MAIN_C] & ~single_clock_option}; // RQ14
			halt_d     = wr_data[ipdw_pkg::BIT_HALT]; // RQ15
		end
		if (stop_wake) begin
			osc_ctrl_d = cpu_choice_q ? ipdw_pkg::OSC_SINGLE : ipdw_pkg::OSC_SLOW; // RQ17
		end
		if (halt_q && |(flags_all & halt_wake_q)) begin
			halt_d = 1'b0; // RQ18
		end
	end

	always_ff @(posedge clk_sys) begin
		if (clr_all) begin
			cpu_choice_q <= 1'b0;
			div_choice_q <= 1'b0;
			osc_ctrl_q   <= ipdw_pkg::OSC_DUAL;
			halt_q       <= 1'b0;
		end else begin
			if (wr_clk_sel) begin
				cpu_choice_q <= wr_data[ipdw_pkg::BIT_CPU_CHOICE]; // RQ7
				div_choice_q <= wr_data[ipdw_pkg::BIT_DIV_CHOICE]; // RQ8
			end
			osc_ctrl_q <= osc_ctrl_d;
			halt_q     <= halt_d;
		end
	end

	wire ipdw_pkg::ipdw_osc_mode_t osc_mode = ipdw_pkg::ipdw_osc_mode_t'(osc_ctrl_q);
	logic main_on, xtal_on;
	always_comb begin
		case (osc_mode)
			ipdw_pkg::IPDW_DUAL:   begin main_on = 1'b1; xtal_on = 1'b1; end // RQ13
			ipdw_pkg::IPDW_SINGLE: begin main_on = 1'b1; xtal_on = 1'b0; end // RQ13
			ipdw_pkg::IPDW_SLOW:   begin main_on = 1'b0; xtal_on = 1'b1; end // RQ13
			ipdw_pkg::IPDW_STOP:   begin main_on = 1'b0; xtal_on = 1'b0; end // RQ13
			default:               begin main_on = 1'b1; xtal_on = 1'b1; end
		endcase
	end

	// ==========================================================
	// watchdog, stepped by the divider
	wire wd_step = watchdog_option & div_src_tick & ~div_q[ipdw_pkg::WD_STEP_BIT]
		& div_inc[ipdw_pkg::WD_STEP_BIT]; // RQ19
	wire wd_over = wd_step & (&wd_q) & ~hot_q;
	wire wd_clr  = wr_wdog & wr_data[ipdw_pkg::BIT_WD_CLR];

	always_ff @(posedge clk_sys) begin
		if (clr_all || wd_clr) begin
			wd_q <= 6'h00; // RQ21
		end else if (wd_step) begin
			wd_q <= wd_q + 6'h01; // RQ19
		end
	end

	// reset-seen survives the hot reset; only the pin reset clears it outright
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			wd_seen_q <= 1'b0; // RQ21
			hot_q     <= 1'b0;
		end else begin
			hot_q <= wd_over; // RQ20
			if (wd_over) begin
				wd_seen_q <= 1'b1; // RQ20
			end else if (wd_clr) begin
				wd_seen_q <= 1'b0; // RQ21
			end
		end
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge clk_sys) begin
		if (clr_all) begin
			irq_q     <= 1'b0;
			cpu_en_q  <= 1'b1;
			main_en_q <= 1'b1;
			xtal_en_q <= 1'b1;
		end else begin
			irq_q     <= |(flags_all & irq_en_q); // RQ23
			cpu_en_q  <= ~halt_q & ~stop_mode; // RQ15
			main_en_q <= main_on;
			xtal_en_q <= xtal_on;
		end
	end

	// ==========================================================
	// read mux, unmapped reads return zero
	logic [7:0] rd_byte;
	always_comb begin
		case (reg_idx)
			ipdw_pkg::IDX_IRQ_FLAGS:  rd_byte = {2'b00, flags_all, 1'b0};
			ipdw_pkg::IDX_TAP_FLAGS:  rd_byte = tap_flag_q;
			ipdw_pkg::IDX_CLK_SELECT: rd_byte = {div_choice_q, 6'h00, cpu_choice_q};
			ipdw_pkg::IDX_DIV_UPPER:  rd_byte = div_q[15:8]; // RQ9
			ipdw_pkg::IDX_WDOG_CTRL:  rd_byte = {wd_seen_q, 7'h00};
			ipdw_pkg::IDX_PWR_CTRL:   rd_byte = {5'h00, osc_ctrl_q[1], osc_ctrl_q[0], halt_q};
			default:                  rd_byte = ipdw_pkg::BYTE_ZERO;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= bus_req;
			rdata_q <= {24'h000000, rd_byte};
		end
	end

	assign wb_ack_o               = ack_q;
	assign wb_dat_o               = rdata_q;
	assign irq_request            = irq_q;
	assign processor_clock_enable = cpu_en_q;
	assign main_osc_enable        = main_en_q;
	assign crystal_osc_enable     = xtal_en_q;
	assign cpu_clock_choice       = cpu_choice_q;
	assign hot_reset              = hot_q;

	// ==========================================================
	// assertions
	property p_port_edge;
		@(posedge clk_sys) disable iff (clr_all)
		(p0_edge && !stop_wake) |=> irq_flag_q[ipdw_pkg::BIT_PORT0];
	endproperty
	a_port_edge: assert property (p_port_edge) else $error("port edge lost"); // RQ1

	property p_timer_set;
		@(posedge clk_sys) disable iff (clr_all)
		events_i.first_timer_event |=> irq_flag_q[ipdw_pkg::BIT_TMR1];
	endproperty
	a_timer_set: assert property (p_timer_set) else $error("timer flag not set"); // RQ2

	property p_flag_sticky;
		@(posedge clk_sys) disable iff (clr_all)
		(irq_flag_q[ipdw_pkg::BIT_TMR2] && !wr_interrupt_flag_clear) |=> irq_flag_q[ipdw_pkg::BIT_TMR2];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped alone"); // RQ3

	property p_clear;
		@(posedge clk_sys) disable iff (clr_all)
		(wr_interrupt_flag_clear && wr_data[ipdw_pkg::BIT_KEY] && !events_i.key_strobe) |=> !irq_flag_q[ipdw_pkg::BIT_KEY];
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed"); // RQ4

	property p_irq_out;
		@(posedge clk_sys) disable iff (clr_all)
		(|(flags_all & irq_en_q)) |=> irq_request;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("irq not raised"); // RQ23

	property p_stop_wake;
		@(posedge clk_sys) disable iff (clr_all)
		(stop_wake && cpu_choice_q) |=> (osc_ctrl_q == ipdw_pkg::OSC_SINGLE) ##1 (main_osc_enable && !crystal_osc_enable);
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("wrong oscillator restarted"); // RQ17

	property p_halt_gate;
		@(posedge clk_sys) disable iff (clr_all)
		halt_q |=> !processor_clock_enable;
	endproperty
	a_halt_gate: assert property (p_halt_gate) else $error("cpu clock not gated"); // RQ15

	property p_wd_hot;
		@(posedge clk_sys) disable iff (!reset_n)
		wd_over |=> (hot_reset && wd_seen_q) ##1 (!hot_reset && irq_en_q == ipdw_pkg::EN_RESET);
	endproperty
	a_wd_hot: assert property (p_wd_hot) else $error("hot reset misbehaved"); // RQ20

	property p_single_opt;
		@(posedge clk_sys) disable iff (clr_all)
		(wr_pwr && single_clock_option && !stop_wake) |=> !osc_ctrl_q[0];
	endproperty
	a_single_opt: assert property (p_single_opt) else $error("low control bit honoured"); // RQ14

endmodule

// *** verification/ipdw_osc_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// oscillator pads facing the block
module ipdw_osc_model #(
	parameter time MAIN_HALF = 51,
	parameter time XTAL_HALF = 203
) (
	input  wire logic main_osc_enable,
	input  wire logic crystal_osc_enable,
	output logic      main_osc_clock,
	output logic      slow_crystal_clock
);
	initial begin
		main_osc_clock = 1'b0;
		slow_crystal_clock = 1'b0;
	end
	// a stopped oscillator holds its level, so no stray divider ticks
	always #MAIN_HALF main_osc_clock = main_osc_enable ? ~main_osc_clock : main_osc_clock;
	always #XTAL_HALF slow_crystal_clock = crystal_osc_enable ? ~slow_crystal_clock : slow_crystal_clock;
endmodule

// *** verification/irq_power_divider_watchdog_test.sv ***
`timescale 1ns/1ps
module irq_power_divider_watchdog_test;
	// ==========================================================
	// signals
	logic                        clk_sys;
	logic                        reset_n;
	logic                        cyc;
	logic                        stb;
	logic                        we;
	logic [ipdw_pkg::ADR_W-1:0]  adr;
	logic [3:0]                  sel;
	logic [ipdw_pkg::DAT_W-1:0]  dat_w;
	logic [ipdw_pkg::DAT_W-1:0]  dat_r;
	logic                        ack;
	ipdw_pkg::ipdw_events_t      ev;
	logic                        pin0;
	logic                        pin4;
	logic                        out0;
	logic                        out4;
	logic                        single_opt;
	logic                        wd_opt;
	logic                        main_clk;
	logic                        xtal_clk;
	logic                        irq;
	logic                        pclk_en;
	logic                        main_en;
	logic                        xtal_en;
	logic                        cpu_choice;
	logic                        hot_rst;
	logic [7:0]                  r;
	logic [7:0]                  e;
	logic [7:0]                  fb [3] = '{8'h02, 8'h08, 8'h10};
	logic [7:0]                  om [3] = '{8'h00, 8'h02, 8'h04};
	logic [1:0]                  oe [3] = '{2'b11, 2'b10, 2'b01};
	logic [7:0]                  tm [2] = '{8'h01, 8'h02};
	int                          n_fail;
	int                          comparisons;
	int                          n;

	ipdw_top u_ipdw_top (
		.clk_sys                (clk_sys),
		.reset_n                (reset_n),
		.wb_cyc_i               (cyc),
		.wb_stb_i               (stb),
		.wb_we_i                (we),
		.wb_adr_i               (adr),
		.wb_sel_i               (sel),
		.wb_dat_i               (dat_w),
		.wb_dat_o               (dat_r),
		.wb_ack_o               (ack),
		.events_i               (ev),
		.port_zero_pin_zero     (pin0),
		.port_zero_pin_four     (pin4),
		.pin_zero_is_output     (out0),
		.pin_four_is_output     (out4),
		.main_osc_clock         (main_clk),
		.slow_crystal_clock     (xtal_clk),
		.single_clock_option    (single_opt),
		.watchdog_option        (wd_opt),
		.irq_request            (irq),
		.processor_clock_enable (pclk_en),
		.main_osc_enable        (main_en),
		.crystal_osc_enable     (xtal_en),
		.cpu_clock_choice       (cpu_choice),
		.hot_reset              (hot_rst)
	);

	ipdw_osc_model u_ipdw_osc_model (
		.main_osc_enable    (main_en),
		.crystal_osc_enable (xtal_en),
		.main_osc_clock     (main_clk),
		.slow_crystal_clock (xtal_clk)
	);

	initial clk_sys = 1'b0;
	always #12.5 clk_sys = ~clk_sys;

	// ==========================================================
	// bus and check tasks
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one classic cycle; no fixed latency assumed
	task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= {idx, 2'b00};
		sel <= 4'hF;
		dat_w <= {24'h000000, wd};
		do begin
			@(posedge clk_sys);
			k++;
		end while (ack !== 1'b1 && k < 20);
		r = dat_r[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (k >= 20) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		xfer(idx, 1'b1, d);
	endtask

	task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
		xfer(idx, 1'b0, 8'h00);
		check8(r, exp);
	endtask

	task automatic pulse(input logic [2:0] v);
		@(posedge clk_sys);
		ev <= v;
		@(posedge clk_sys);
		ev <= 3'b000;
	endtask

	task automatic wrap_up();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#(25 * 40000);
		n_fail++;
		$display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		wrap_up();
	end

	// ==========================================================
	// sequence
	initial begin
		{reset_n, cyc, stb, we, pin0, pin4, out0, out4, single_opt} = '0;
		adr = '0;
		sel = '0;
		dat_w = '0;
		ev = '0;
		wd_opt = 1'b1;
		n_fail = 0;
		comparisons = 0;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, 8'h00);
		rd_chk(ipdw_pkg::IDX_CLK_SELECT, 8'h00);
		rd_chk(ipdw_pkg::IDX_PWR_CTRL, 8'h00);
		rd_chk(ipdw_pkg::IDX_WDOG_CTRL, 8'h00);
		rd_chk(ipdw_pkg::IDX_TAP_FLAGS, 8'h00);
		rd_chk(ipdw_pkg::IDX_DIV_UPPER, 8'h00);
		rd_chk(ipdw_pkg::IDX_HALT_WAKE, 8'h00);
		rd_chk(10'h0C0, 8'h00);
		check8({pclk_en, main_en, xtal_en, cpu_choice, irq, 3'b000}, 8'hE0);
		// events land while masked; flags must hold through enable
		e = 8'h00;
		for (int i = 0; i < 3; i++) begin
			pulse(3'b100 >> i);
			e = e | fb[i];
			rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, e);
		end
		check8({7'h00, irq}, 8'h00);
		wr(ipdw_pkg::IDX_IRQ_FLAGS, 8'h1A);
		repeat (2) @(posedge clk_sys);
		check8({7'h00, irq}, 8'h01);
		rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, 8'h1A);
		for (int i = 0; i < 3; i++) begin
			wr(ipdw_pkg::IDX_IRQ_CLEAR, fb[i]);
			e = e & ~fb[i];
			rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, e);
		end
		repeat (2) @(posedge clk_sys);
		check8({7'h00, irq}, 8'h00);
		// both edges count; a pin in output mode is ignored
		pin0 <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, 8'h04);
		wr(ipdw_pkg::IDX_IRQ_CLEAR, 8'h04);
		pin0 <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, 8'h04);
		wr(ipdw_pkg::IDX_IRQ_CLEAR, 8'h04);
		out4 <= 1'b1;
		pin4 <= 1'b1;
		repeat (8) @(posedge clk_sys);
		pin4 <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, 8'h00);
		out4 <= 1'b0;
		repeat (8) @(posedge clk_sys);
		pin4 <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, 8'h04);
		wr(ipdw_pkg::IDX_IRQ_CLEAR, 8'h04);
		// halt and wake on an enabled timer event
		wr(ipdw_pkg::IDX_HALT_WAKE, 8'h08);
		wr(ipdw_pkg::IDX_PWR_CTRL, 8'h01);
		repeat (2) @(posedge clk_sys);
		check8({5'h00, pclk_en, main_en, xtal_en}, 8'h03);
		pulse(3'b010);
		for (n = 0; n < 50 && pclk_en !== 1'b1; n++) @(posedge clk_sys);
		check8({7'h00, pclk_en}, 8'h01);
		wr(ipdw_pkg::IDX_PWR_CTRL, 8'h00);
		wr(ipdw_pkg::IDX_IRQ_CLEAR, 8'h08);
		wr(ipdw_pkg::IDX_HALT_WAKE, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(ipdw_pkg::IDX_PWR_CTRL, om[i]);
			repeat (2) @(posedge clk_sys);
			check8({6'h00, main_en, xtal_en}, {6'h00, oe[i]});
		end
		single_opt <= 1'b1;
		wr(ipdw_pkg::IDX_PWR_CTRL, 8'h06);
		repeat (2) @(posedge clk_sys);
		check8({6'h00, main_en, xtal_en}, 8'h01);
		rd_chk(ipdw_pkg::IDX_PWR_CTRL, 8'h04);
		single_opt <= 1'b0;
		wr(ipdw_pkg::IDX_PWR_CTRL, 8'h00);
		// main oscillator feeds cpu and divider from here on
		wr(ipdw_pkg::IDX_CLK_SELECT, 8'h81);
		rd_chk(ipdw_pkg::IDX_CLK_SELECT, 8'h81);
		check8({7'h00, cpu_choice}, 8'h01);
		for (int t = 0; t < 2; t++) begin
			wr(ipdw_pkg::IDX_TAP_FLAGS, tm[t]);
			r = 8'h00;
			for (n = 0; n < 3000 && (r & tm[t]) !== tm[t]; n++) xfer(ipdw_pkg::IDX_TAP_FLAGS, 1'b0, 8'h00);
			check8(r, tm[t]);
			rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, 8'h20);
			wr(ipdw_pkg::IDX_TAP_FLAGS, 8'h00);
			wr(ipdw_pkg::IDX_TAP_CLEAR, tm[t]);
			wr(ipdw_pkg::IDX_IRQ_CLEAR, 8'h20);
			rd_chk(ipdw_pkg::IDX_TAP_FLAGS, 8'h00);
			rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, 8'h00);
		end
		wr(ipdw_pkg::IDX_WDOG_CTRL, 8'h01);
		rd_chk(ipdw_pkg::IDX_WDOG_CTRL, 8'h00);
		// stop: timer event must not wake, port edge must
		wr(ipdw_pkg::IDX_IRQ_FLAGS, 8'h04);
		wr(ipdw_pkg::IDX_PWR_CTRL, 8'h06);
		repeat (2) @(posedge clk_sys);
		check8({5'h00, pclk_en, main_en, xtal_en}, 8'h00);
		pulse(3'b010);
		repeat (4) @(posedge clk_sys);
		check8({6'h00, main_en, xtal_en}, 8'h00);
		pin0 <= 1'b1;
		for (n = 0; n < 50 && main_en !== 1'b1; n++) @(posedge clk_sys);
		repeat (2) @(posedge clk_sys);
		check8({5'h00, pclk_en, main_en, xtal_en}, 8'h06);
		rd_chk(ipdw_pkg::IDX_PWR_CTRL, 8'h02);
		rd_chk(ipdw_pkg::IDX_DIV_UPPER, 8'h00);
		rd_chk(ipdw_pkg::IDX_TAP_FLAGS, 8'h00);
		wr(ipdw_pkg::IDX_IRQ_CLEAR, 8'h0C);
		wr(ipdw_pkg::IDX_IRQ_FLAGS, 8'h00);
		rd_chk(ipdw_pkg::IDX_IRQ_FLAGS, 8'h00);
		check8({7'h00, hot_rst}, 8'h00);
		wrap_up();
	end
endmodule
